// ### inc/pps_pkg.sv
// constants, types and register map of the remappable pin select block
package pps_pkg;
    localparam int          SEL_W       = 6;
    localparam int          NUM_OUT     = 32;
    localparam int          NUM_OUT_REG = 16;
    localparam int          NUM_PIN     = 44;
    localparam int          NUM_SRC     = 37;
    localparam int          NUM_EV      = 4;
    localparam logic [11:0] OSC_OFS     = 12'h000;
    localparam logic [11:0] STAT_OFS    = 12'h004;
    localparam logic [11:0] MASK_OFS    = 12'h008;
    localparam logic [11:0] CFG_OFS     = 12'h00c;
    localparam logic [11:0] OUT_BASE    = 12'h100;
    localparam logic [11:0] IN_BASE     = 12'h200;
    localparam int          LOCK_BIT    = 6;
    localparam int          ONE_WAY_BIT = 4;
    localparam int          HI_LSB      = 8;
    localparam logic [7:0]  KEY_ONE     = 8'h46;
    localparam logic [7:0]  KEY_TWO     = 8'h57;
    localparam logic [5:0]  OUT_NULL    = 6'h00;
    localparam logic [5:0]  IN_RESET    = 6'h3f;
    localparam logic [5:0]  IN_MAX      = 6'h2b;
    localparam logic        ONE_WAY_RST = 1'b1;
    localparam logic        LOCK_RST    = 1'b0;
    // status and mask bit positions
    localparam int          EV_KEY      = 0;
    localparam int          EV_LOCK     = 1;
    localparam int          EV_BLOCK    = 2;
    localparam int          EV_MISMATCH = 3;

    typedef enum logic [1:0] {
        KS_IDLE = 2'b00,
        KS_KEY1 = 2'b01,
        KS_KEY2 = 2'b10
    } pps_key_state_t;

    typedef struct packed {
        logic [5:0] hi;
        logic [5:0] lo;
    } pps_sel_pair_t;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } pps_apb_req_t;

    typedef struct packed {
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
    } pps_apb_rsp_t;
endpackage

// ### hdl/pps_out_select.sv
// remappable pin select: output matrix, input selectors, write lock and shadow monitor
//
// How it works
// - each output register holds two 6-bit fields, one per remappable pin
// - code zero disconnects the pin from every peripheral output
// - codes 1-12, 18-25, 28-36 pick peripheral outputs; others drive nothing
// - reset puts every output selector at the null code
// - any output may drive many pins, any pin may feed many inputs
// - input codes above 43 or for absent pins give a low input
// - fields of absent output pins ignore writes and read zero
// - while locked, selector writes complete but change nothing
// - lock bit is bit 6 of the oscillator control register
// - write 46h, then 57h, then the lock value in one write
// - lock bit holds its value until deliberately changed
// - shadow copies are compared always; a mismatch raises a reset request
// - with one-way option set, a set lock cannot be cleared before reset
// - one-way option resets to active; writing zero allows many sessions
// - up to 44 pins, 32 bidirectional and 12 input only
// - small package lacks pins 5, 15, 30, 31, 32-36 and 38-43
// - input selectors reset to all ones, tying inputs low
// - lock bit resets unlocked
//
// Our own choices: register access over APB and the register addresses.
`timescale 1ns/1ps
module pps_out_select #(
    parameter int NUM_IN_REGS = 30,
    parameter bit SMALL_PKG   = 1'b0
) (
    input  wire logic                       clk_sys,
    input  wire logic                       rst_b,
    input  wire pps_pkg::pps_apb_req_t      apbReq,
    output pps_pkg::pps_apb_rsp_t           apbRsp,
    input  wire logic [pps_pkg::NUM_SRC-1:0] periphOut,
    input  wire logic [pps_pkg::NUM_PIN-1:0] pinIn,
    output logic [pps_pkg::NUM_OUT-1:0]     pinOut,
    output logic [pps_pkg::NUM_OUT-1:0]     pinOutEn,
    output logic [2*NUM_IN_REGS-1:0]        periphIn,
    output logic                            cfgMismatchRst,
    output logic                            irq
);
    import pps_pkg::*;

    if (NUM_IN_REGS < 1 || NUM_IN_REGS > 32) begin : g_chk
        $error("NUM_IN_REGS must be 1 to 32");
    end

    // pin present on this package
    function automatic logic pinImpl(input logic [5:0] code);
        logic ok;
        ok = (code <= IN_MAX);
        if (SMALL_PKG) begin
            if (code == 6'h05 || code == 6'h0f || code == 6'h1e || code == 6'h1f)
                ok = 1'b0;
            if (code >= 6'h20 && code != 6'h25)
                ok = 1'b0;
        end
        return ok;
    endfunction

    // output code names a real peripheral output
    function automatic logic outValid(input logic [5:0] code);
        return (code >= 6'h01 && code <= 6'h0c) || (code >= 6'h12 && code <= 6'h19)
            || (code >= 6'h1c && code <= 6'h24);
    endfunction

    pps_sel_pair_t  outSel_r  [NUM_OUT_REG];
    pps_sel_pair_t  outShd_r  [NUM_OUT_REG];
    pps_sel_pair_t  inSel_r   [NUM_IN_REGS];
    pps_sel_pair_t  inShd_r   [NUM_IN_REGS];
    pps_key_state_t keyState_r;
    logic                lock_r;
    logic                oneWay_r;
    logic [NUM_EV-1:0]   stat_r;
    logic [NUM_EV-1:0]   mask_r;
    logic [NUM_EV-1:0]   events;
    logic [NUM_PIN-1:0]  sync1_r;
    logic [NUM_PIN-1:0]  sync2_r;
    logic [NUM_PIN-1:0]  sync3_r;
    logic [NUM_PIN-1:0]  pinFlt_r;
    logic [5:0]          outCode   [NUM_OUT];
    logic [5:0]          inCode    [2*NUM_IN_REGS];
    logic                wrEn;
    logic                oscWr;
    logic                outWr;
    logic                inWr;
    logic                mismatch;
    logic [4:0]          regIdx;
    logic [7:0]          wrByte;
    logic                lockNxt;
    logic [31:0]         rdData;
    logic                rdErr;

    // bus write strobe at the access edge
    assign wrEn   = apbReq.psel & apbReq.penable & apbRsp.pready & apbReq.pwrite;
    assign regIdx = apbReq.paddr[6:2];
    assign wrByte = apbReq.pwdata[7:0];
    assign oscWr  = wrEn && apbReq.paddr == OSC_OFS;
    assign outWr  = wrEn && apbReq.paddr >= OUT_BASE
                    && apbReq.paddr < OUT_BASE + 12'(4 * NUM_OUT_REG)
                    && apbReq.paddr[1:0] == 2'b00;
    assign inWr   = wrEn && apbReq.paddr >= IN_BASE
                    && apbReq.paddr < IN_BASE + 12'(4 * NUM_IN_REGS)
                    && apbReq.paddr[1:0] == 2'b00;

    // flat views of the selector fields
    for (genvar p = 0; p < NUM_OUT / 2; p++) begin : g_oc
        assign outCode[2*p]   = outSel_r[p].lo;
        assign outCode[2*p+1] = outSel_r[p].hi;
    end
    for (genvar q = 0; q < NUM_IN_REGS; q++) begin : g_ic
        assign inCode[2*q]   = inSel_r[q].lo;
        assign inCode[2*q+1] = inSel_r[q].hi;
    end

    // apb answer: ready one cycle after setup, unmapped gives pslverr
    always_comb begin
        rdData = 32'h0000_0000;
        rdErr  = 1'b0;
        if (apbReq.paddr == OSC_OFS) begin
            rdData[LOCK_BIT] = lock_r;
        end else if (apbReq.paddr == STAT_OFS) begin
            rdData[NUM_EV-1:0] = stat_r;
        end else if (apbReq.paddr == MASK_OFS) begin
            rdData[NUM_EV-1:0] = mask_r;
        end else if (apbReq.paddr == CFG_OFS) begin
            rdData[ONE_WAY_BIT] = oneWay_r;
        end else if (apbReq.paddr >= OUT_BASE && apbReq.paddr < OUT_BASE + 12'h040
                     && apbReq.paddr[1:0] == 2'b00) begin
            rdData[5:0]           = outSel_r[regIdx[3:0]].lo;
            rdData[HI_LSB+5:HI_LSB] = outSel_r[regIdx[3:0]].hi;
        end else if (inWr | (apbReq.paddr >= IN_BASE
                     && apbReq.paddr < IN_BASE + 12'(4 * NUM_IN_REGS)
                     && apbReq.paddr[1:0] == 2'b00)) begin
            rdData[5:0]           = inSel_r[regIdx].lo;
            rdData[HI_LSB+5:HI_LSB] = inSel_r[regIdx].hi;
        end else begin
            rdErr = 1'b1;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            apbRsp <= '0;
        end else begin
            apbRsp.pready  <= apbReq.psel & ~apbReq.penable & ~apbRsp.pready;
            apbRsp.pslverr <= rdErr;
            apbRsp.prdata  <= apbReq.pwrite ? 32'h0000_0000 : rdData;
        end
    end

    // unlock key sequence; any other write aborts it
    always_comb begin
        lockNxt = lock_r;
        if (oscWr && keyState_r == KS_KEY2) begin
            lockNxt = apbReq.pwdata[LOCK_BIT];
            if (oneWay_r && lock_r)
                lockNxt = 1'b1;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            keyState_r <= KS_IDLE;
        end else if (wrEn) begin
            case (keyState_r)
                KS_IDLE: begin
                    keyState_r <= (oscWr && wrByte == KEY_ONE) ? KS_KEY1 : KS_IDLE;
                end
                KS_KEY1: begin
                    keyState_r <= (oscWr && wrByte == KEY_TWO) ? KS_KEY2 : KS_IDLE;
                end
                default: begin
                    keyState_r <= KS_IDLE;
                end
            endcase
        end
    end

    // lock bit changes only through the key sequence
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            lock_r <= LOCK_RST;
        end else begin
            lock_r <= lockNxt;
        end
    end

    // one-way option, changeable only while unlocked
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            oneWay_r <= ONE_WAY_RST;
        end else if (wrEn && apbReq.paddr == CFG_OFS && !lock_r) begin
            oneWay_r <= apbReq.pwdata[ONE_WAY_BIT];
        end
    end

    // output selectors and their shadows
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            for (int i = 0; i < NUM_OUT_REG; i++) begin
                outSel_r[i] <= '{hi: OUT_NULL, lo: OUT_NULL};
                outShd_r[i] <= '{hi: OUT_NULL, lo: OUT_NULL};
            end
        end else if (outWr && !lock_r) begin
            if (pinImpl({regIdx, 1'b0})) begin
                outSel_r[regIdx[3:0]].lo <= apbReq.pwdata[5:0];
                outShd_r[regIdx[3:0]].lo <= apbReq.pwdata[5:0];
            end
            if (pinImpl({regIdx, 1'b1})) begin
                outSel_r[regIdx[3:0]].hi <= apbReq.pwdata[HI_LSB+5:HI_LSB];
                outShd_r[regIdx[3:0]].hi <= apbReq.pwdata[HI_LSB+5:HI_LSB];
            end
        end
    end

    // input selectors and their shadows
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            for (int i = 0; i < NUM_IN_REGS; i++) begin
                inSel_r[i] <= '{hi: IN_RESET, lo: IN_RESET};
                inShd_r[i] <= '{hi: IN_RESET, lo: IN_RESET};
            end
        end else if (inWr && !lock_r) begin
            inSel_r[regIdx].lo <= apbReq.pwdata[5:0];
            inSel_r[regIdx].hi <= apbReq.pwdata[HI_LSB+5:HI_LSB];
            inShd_r[regIdx].lo <= apbReq.pwdata[5:0];
            inShd_r[regIdx].hi <= apbReq.pwdata[HI_LSB+5:HI_LSB];
        end
    end

    // continuous shadow comparison
    always_comb begin
        mismatch = 1'b0;
        for (int i = 0; i < NUM_OUT_REG; i++)
            mismatch = mismatch | (outSel_r[i] != outShd_r[i]);
        for (int i = 0; i < NUM_IN_REGS; i++)
            mismatch = mismatch | (inSel_r[i] != inShd_r[i]);
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            cfgMismatchRst <= 1'b0;
        end else begin
            cfgMismatchRst <= mismatch;
        end
    end

    // output matrix: each pin picks its own source, sources may repeat
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            pinOut   <= '0;
            pinOutEn <= '0;
        end else begin
            for (int p = 0; p < NUM_OUT; p++) begin
                pinOutEn[p] <= outValid(outCode[p]);
                pinOut[p]   <= outValid(outCode[p]) ? periphOut[outCode[p]] : 1'b0;
            end
        end
    end

    // pin input synchronisers, a change counts when stages two and three agree
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            sync1_r  <= '0;
            sync2_r  <= '0;
            sync3_r  <= '0;
            pinFlt_r <= '0;
        end else begin
            sync1_r  <= pinIn;
            sync2_r  <= sync1_r;
            sync3_r  <= sync2_r;
            pinFlt_r <= (sync2_r & sync3_r) | (pinFlt_r & (sync2_r ^ sync3_r));
        end
    end

    // input routing, invalid or absent pins feed a low level
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            periphIn <= '0;
        end else begin
            for (int f = 0; f < 2 * NUM_IN_REGS; f++)
                periphIn[f] <= pinImpl(inCode[f]) ? pinFlt_r[inCode[f]] : 1'b0;
        end
    end

    // events, sticky status with set winning over clear, mask and interrupt
    assign events[EV_KEY]      = oscWr && keyState_r == KS_KEY2;
    assign events[EV_LOCK]     = lockNxt != lock_r;
    assign events[EV_BLOCK]    = (outWr | inWr) & lock_r;
    assign events[EV_MISMATCH] = mismatch;

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            stat_r <= '0;
            mask_r <= '0;
        end else begin
            if (wrEn && apbReq.paddr == STAT_OFS)
                stat_r <= (stat_r & ~apbReq.pwdata[NUM_EV-1:0]) | events;
            else
                stat_r <= stat_r | events;
            if (wrEn && apbReq.paddr == MASK_OFS)
                mask_r <= apbReq.pwdata[NUM_EV-1:0];
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            irq <= 1'b0;
        end else begin
            irq <= |(stat_r & mask_r);
        end
    end

    // checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);

    sequence s_key_one;
        oscWr && keyState_r == KS_IDLE && wrByte == KEY_ONE;
    endsequence
    sequence s_key_two;
        oscWr && wrByte == KEY_TWO;
    endsequence

    a_key_first_step: assert property (s_key_one |=> keyState_r == KS_KEY1)
        else $error("first key write not taken");
    a_key_reach_arm: assert property (keyState_r == KS_KEY1 ##0 s_key_two
        |=> keyState_r == KS_KEY2) else $error("key pair did not arm lock change");
    a_key_lock_set: assert property (oscWr && keyState_r == KS_KEY2
        && !(oneWay_r && lock_r) |=> lock_r == $past(apbReq.pwdata[LOCK_BIT]))
        else $error("lock write not applied");
    a_lock_sticky: assert property (!(oscWr && keyState_r == KS_KEY2)
        |=> $stable(lock_r)) else $error("lock bit changed without sequence");
    a_one_way_hold: assert property (oneWay_r && lock_r |=> lock_r)
        else $error("one-way lock cleared");
    a_locked_out_keep: assert property (outWr && lock_r
        |=> outSel_r[$past(regIdx[3:0])] == $past(outSel_r[regIdx[3:0]]))
        else $error("locked output selector changed");
    a_abort_seq: assert property (wrEn && !oscWr |=> keyState_r == KS_IDLE)
        else $error("unlock not aborted");
    a_null_no_drive: assert property (outCode[0] == OUT_NULL
        |=> !pinOutEn[0] && !pinOut[0]) else $error("null code drives pin");
    a_decode_en: assert property (##1 pinOutEn[1] == outValid($past(outCode[1])))
        else $error("output enable decode wrong");
    a_bad_input_low: assert property (inCode[0] > IN_MAX |=> !periphIn[0])
        else $error("invalid input code passes a level");
    a_absent_field: assert property (SMALL_PKG |-> outCode[5] == OUT_NULL)
        else $error("absent pin field written");
    a_mismatch_rst: assert property (mismatch |=> cfgMismatchRst)
        else $error("mismatch reset missing");
endmodule

// ### test/pps_far_side.sv
// model of the peripherals and pads on the far side of the pin select block
`timescale 1ns/1ps
module pps_far_side (
    input  wire logic                       clk_sys,
    input  wire logic                       rst_b,
    input  wire logic [pps_pkg::NUM_SRC-1:0] srcNext,
    input  wire logic [pps_pkg::NUM_PIN-1:0] pinNext,
    output logic [pps_pkg::NUM_SRC-1:0]     periphOut,
    output logic [pps_pkg::NUM_PIN-1:0]     pinIn
);
    import pps_pkg::*;
    // peripheral outputs and pad levels change only after a clock edge
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            periphOut <= '0;
            pinIn     <= '0;
        end else begin
            periphOut <= srcNext;
            pinIn     <= pinNext;
        end
    end
endmodule

// ### test/tb_top.sv
// self-checking bench of the remappable pin select block
`timescale 1ns/1ps
module tb_top;
    import pps_pkg::*;
    logic               clk_sys;
    logic               rst_b;
    pps_apb_req_t       apbReq;
    pps_apb_rsp_t       apbRsp;
    logic [NUM_SRC-1:0] periphOut;
    logic [NUM_SRC-1:0] srcNext;
    logic [NUM_PIN-1:0] pinIn;
    logic [NUM_PIN-1:0] pinNext;
    logic [NUM_OUT-1:0] pinOut;
    logic [NUM_OUT-1:0] pinOutEn;
    logic [59:0]        periphIn;
    logic [NUM_OUT-1:0] smallOutEn;
    logic [59:0]        smallIn;
    logic               cfgMismatchRst;
    logic               irq;
    logic [32:0]        expQ[$];
    logic [15:0]        lfsr;
    logic [31:0]        oldSel;
    int                 errors;
    int                 n_tests;
    int                 k;
    bit                 v;

    pps_out_select #(.NUM_IN_REGS(30), .SMALL_PKG(1'b0)) uut (
        .clk_sys(clk_sys), .rst_b(rst_b), .apbReq(apbReq), .apbRsp(apbRsp),
        .periphOut(periphOut), .pinIn(pinIn), .pinOut(pinOut), .pinOutEn(pinOutEn),
        .periphIn(periphIn), .cfgMismatchRst(cfgMismatchRst), .irq(irq));
    // small package copy on the same bus
    pps_out_select #(.NUM_IN_REGS(30), .SMALL_PKG(1'b1)) uutSmall (
        .clk_sys(clk_sys), .rst_b(rst_b), .apbReq(apbReq), .apbRsp(),
        .periphOut(periphOut), .pinIn(pinIn), .pinOut(), .pinOutEn(smallOutEn),
        .periphIn(smallIn), .cfgMismatchRst(), .irq());
    pps_far_side far (
        .clk_sys(clk_sys), .rst_b(rst_b), .srcNext(srcNext), .pinNext(pinNext),
        .periphOut(periphOut), .pinIn(pinIn));

    // 40 MHz clock
    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end

    function automatic logic [15:0] nextRand(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
        n_tests++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic summarize;
        if (errors == 0 && n_tests > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // one apb transfer; the expected answer is queued for the monitor
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                       input logic [32:0] exp);
        int n;
        expQ.push_back(exp);
        @(posedge clk_sys);
        apbReq.psel    <= 1'b1;
        apbReq.penable <= 1'b0;
        apbReq.pwrite  <= wr;
        apbReq.paddr   <= a;
        apbReq.pwdata  <= d;
        @(posedge clk_sys);
        apbReq.penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (apbRsp.pready !== 1'b1 && n < 20);
        if (apbRsp.pready !== 1'b1) begin
            errors++;
            summarize();
        end
        apbReq.psel    <= 1'b0;
        apbReq.penable <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 33'h0);
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0, {1'b0, e});
    endtask

    task automatic keySeq(input logic [31:0] lockVal);
        wr(OSC_OFS, {24'h0, KEY_ONE});
        wr(OSC_OFS, {24'h0, KEY_TWO});
        wr(OSC_OFS, lockVal);
    endtask

    task automatic doReset;
        rst_b <= 1'b0;
        repeat (3) @(posedge clk_sys);
        rst_b <= 1'b1;
    endtask

    // compares each completed transfer with the oldest queued note
    always @(posedge clk_sys) begin
        if (apbReq.psel && apbReq.penable && apbRsp.pready === 1'b1) begin
            chk({apbRsp.pslverr, apbRsp.prdata}, expQ.pop_front());
        end
    end

    // hang guard
    initial begin
        repeat (50000) @(posedge clk_sys);
        errors++;
        summarize();
    end

    // main sequence
    initial begin
        errors = 0;
        n_tests = 0;
        lfsr = 16'd29339;
        apbReq = '0;
        srcNext = '0;
        pinNext = '0;
        rst_b = 1'b0;
        doReset();
        rd(OUT_BASE, 32'h0);
        rd(IN_BASE, {18'h0, IN_RESET, 2'b00, IN_RESET});
        rd(CFG_OFS, 32'h10);
        chk({1'b0, pinOutEn}, 33'h0);
        // every output code on both fields of pins 0 and 1
        for (int c = 0; c < 64; c++) begin
            lfsr = nextRand(lfsr);
            srcNext <= {lfsr[4:0], lfsr, lfsr};
            wr(OUT_BASE, {18'h0, c[5:0], 2'b00, c[5:0]});
            repeat (2) @(posedge clk_sys);
            #1;
            v = (c >= 1 && c <= 12) || (c >= 18 && c <= 25) || (c >= 28 && c <= 36);
            chk({1'b0, pinOutEn}, {31'h0, v, v});
            chk({31'h0, pinOut[1:0]}, {31'h0, {2{v ? srcNext[c] : 1'b0}}});
        end
        // input selectors: pin 3 on the low field, invalid code 44 on the high
        pinNext <= '1;
        wr(IN_BASE, {18'h0, 6'd44, 2'b00, 6'd3});
        k = 0;
        while (periphIn[0] !== 1'b1 && k < 20) begin
            @(posedge clk_sys);
            k++;
        end
        if (k >= 20) begin
            errors++;
            summarize();
        end
        #1;
        chk({31'h0, periphIn[1:0]}, 33'h1);
        // lock, blocked write, interrupt raise and clear
        wr(MASK_OFS, 32'h6);
        keySeq(32'h40);
        oldSel = 32'h3f3f;
        wr(OUT_BASE, 32'h0303);
        rd(OUT_BASE, oldSel);
        rd(STAT_OFS, 32'h7);
        repeat (2) @(posedge clk_sys);
        #1;
        chk({32'h0, irq}, 33'h1);
        wr(STAT_OFS, 32'h7);
        repeat (2) @(posedge clk_sys);
        #1;
        chk({32'h0, irq}, 33'h0);
        // one-way option keeps the lock set
        keySeq(32'h0);
        wr(OUT_BASE, 32'h0);
        rd(OUT_BASE, oldSel);
        // reset restores writes; many sessions once the option is off
        doReset();
        rd(OUT_BASE, 32'h0);
        wr(CFG_OFS, 32'h0);
        keySeq(32'h40);
        keySeq(32'h0);
        wr(OUT_BASE, 32'h0807);
        wr(OUT_BASE + 12'h004, 32'h1312);
        rd(OUT_BASE, 32'h0807);
        rd(OUT_BASE + 12'h004, 32'h1312);
        // small package lacks output pin 5 and input pin 40
        wr(OUT_BASE + 12'h008, 32'h0303);
        wr(IN_BASE + 12'h004, {18'h0, 6'd40, 2'b00, 6'd37});
        repeat (8) @(posedge clk_sys);
        #1;
        chk({31'h0, pinOutEn[5:4]}, 33'h3);
        chk({31'h0, smallOutEn[5:4]}, 33'h1);
        chk({31'h0, periphIn[3:2]}, 33'h3);
        chk({31'h0, smallIn[3:2]}, 33'h1);
        // an intervening write aborts the key sequence
        wr(OSC_OFS, {24'h0, KEY_ONE});
        wr(MASK_OFS, 32'h0);
        wr(OSC_OFS, {24'h0, KEY_TWO});
        wr(OSC_OFS, 32'h40);
        wr(OUT_BASE, 32'h2423);
        rd(OUT_BASE, 32'h2423);
        apb(1'b0, 12'hffc, 32'h0, {1'b1, 32'h0});
        chk({32'h0, cfgMismatchRst}, 33'h0);
        summarize();
    end
endmodule
